/* File: hdl/tsscp_top.v */
// Serial command port of a digital temperature sensor
`timescale 1ns/100ps
`include "tsscp_defs.vh"

// Overview of operation
// - Conversions continue during access; reads return last completed result.
// - Chip select falling starts a frame; first 16 clocks shift out data.
// - Response words go out sign bit first, then downward.
// - With chip select still low, next 16 clocks shift in a command.
// - READ is bit 15 set, selector in bits 4:3, others zero.
// - Configuration READ is bits 15 and 3 set; temperature only bit 15.
// - Selector from READ is held until a full 16-bit read completes.
// - Early chip select rise after READ re-presents that register next frame.
// - A complete 16-bit read returns the pointer to temperature.
// - Pointer 00 temp, 01 config, 10 low, 11 high; resets to 00.
// - WRITE commands leave the read pointer untouched.
// - On chip select fall the pointer-selected register is sent first.
// - Commands and response words alternate within one frame.
// - After a WRITE the next response word is temperature.
// - Config WRITE: top nibble zero, fields in 11:3, tail 010.
// - Low-limit WRITE: 13-bit limit in 15:3, tail 100.
// - High-limit WRITE: 13-bit limit in 15:3, tail 110.
// - Low byte all ones requests shutdown after current conversion.
// - Temperature word: 13-bit value, bit 2 one, bits 1:0 released.
// - Data sampled on rising clock edges, driven after falling ones.
module tsscp_top (
    input wire clock,
    input wire rst_n,
    input wire csN,
    input wire sck,
    input wire sdIn,
    output reg sdOut,
    output reg sdOe,
    input wire adcDone,
    input wire adcBusy,
    input wire [12:0] adcResult,
    output wire shutdownActive,
    output reg [1:0] conversionDelayField,
    output reg [1:0] resolutionField,
    output reg [1:0] faultCountField,
    output reg alertPolarity,
    output reg [1:0] thermostatModeField
);

// ----------------------------------------
// Word selection helpers
// ----------------------------------------
function [15:0] selectWord;
    input [1:0] ptr;
    input [12:0] temp;
    input [15:0] cfg;
    input [15:0] lowL;
    input [15:0] highL;
    begin
        case (ptr)
            `TSSCP_PTR_TEMP: selectWord = {temp, `TSSCP_TEMP_TAIL};
            `TSSCP_PTR_CONFIG: selectWord = cfg;
            `TSSCP_PTR_LOW: selectWord = lowL;
            `TSSCP_PTR_HIGH: selectWord = highL;
            default: selectWord = {temp, `TSSCP_TEMP_TAIL};
        endcase
    end
endfunction

function [15:0] selectZMask;
    input [1:0] ptr;
    begin
        if (ptr == `TSSCP_PTR_TEMP) begin
            selectZMask = `TSSCP_TEMP_ZMASK;
        end else begin
            selectZMask = `TSSCP_NO_ZMASK;
        end
    end
endfunction

function tailMatch;
    input [15:0] word;
    input [2:0] tail;
    begin
        tailMatch = (word[2:0] == tail);
    end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
wire csSync;
wire sckSync;
wire sdSync;

tsscp_sync #(
    .WIDTH(3),
    .INIT(3'h4)
) uSync (
    .clock(clock),
    .rst_n(rst_n),
    .pinIn({csN, sck, sdIn}),
    .pinOut({csSync, sckSync, sdSync})
);

// ----------------------------------------
// Edge detection
// ----------------------------------------
reg csPrev_reg;
reg sckPrev_reg;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        csPrev_reg <= 1'b1;
        sckPrev_reg <= 1'b0;
    end else begin
        csPrev_reg <= csSync;
        sckPrev_reg <= sckSync;
    end
end

wire csFall = csPrev_reg & ~csSync;
wire csRise = ~csPrev_reg & csSync;
wire active = ~csSync & ~csPrev_reg;
wire sckRise = active & ~sckPrev_reg & sckSync;
wire sckFall = active & sckPrev_reg & ~sckSync;

// ----------------------------------------
// Conversion side
// ----------------------------------------
wire [12:0] tempResult;
reg shutdownReq_reg;

tsscp_conv uConv (
    .clock(clock),
    .rst_n(rst_n),
    .adcDone(adcDone),
    .adcBusy(adcBusy),
    .adcResult(adcResult),
    .shutdownReq(shutdownReq_reg),
    .tempResult(tempResult),
    .shutdownActive(shutdownActive)
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [15:0] config_reg;
reg [15:0] lowLimit_reg;
reg [15:0] highLimit_reg;
reg [1:0] readPointer_reg;

// ----------------------------------------
// Frame state
// ----------------------------------------
localparam PHASE_RESP = 1'b0;
localparam PHASE_CMD = 1'b1;

reg phase_reg;
reg [4:0] bitCnt_reg;
reg [15:0] txShift_reg;
reg [15:0] zShift_reg;
reg [15:0] rxShift_reg;
reg firstPending_reg;

// ----------------------------------------
// Command decode
// ----------------------------------------
wire lastBit = (bitCnt_reg == `TSSCP_WORD_BITS - 5'h01);
wire [15:0] cmdWord = {rxShift_reg[14:0], sdSync};
wire isRead = ((cmdWord & `TSSCP_READ_MASK) == `TSSCP_READ_BASE);
wire isShutdown = (cmdWord[7:0] == `TSSCP_SHUTDOWN_BYTE);
wire isCfgWrite = (cmdWord[15:12] == `TSSCP_CFG_TOP)
    && tailMatch(cmdWord, `TSSCP_TAIL_CONFIG);
wire isLowWrite = tailMatch(cmdWord, `TSSCP_TAIL_LOW);
wire isHighWrite = tailMatch(cmdWord, `TSSCP_TAIL_HIGH);
wire [1:0] nextPtr = isRead ? cmdWord[`TSSCP_SEL_HI:`TSSCP_SEL_LO]
    : `TSSCP_PTR_TEMP;

// ----------------------------------------
// Word end strobes
// ----------------------------------------
wire respDone = sckRise & lastBit & (phase_reg == PHASE_RESP);
wire cmdDone = sckRise & lastBit & (phase_reg == PHASE_CMD);

// ----------------------------------------
// Words on offer
// ----------------------------------------
wire [15:0] curWord = selectWord(readPointer_reg, tempResult, config_reg,
    lowLimit_reg, highLimit_reg);
wire [15:0] curMask = selectZMask(readPointer_reg);
wire [15:0] nextWord = selectWord(nextPtr, tempResult, config_reg,
    lowLimit_reg, highLimit_reg);
wire [15:0] nextMask = selectZMask(nextPtr);

// ----------------------------------------
// Serial engine
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        phase_reg <= PHASE_RESP;
        bitCnt_reg <= 5'h00;
        txShift_reg <= 16'h0000;
        zShift_reg <= 16'h0000;
        rxShift_reg <= 16'h0000;
        firstPending_reg <= 1'b0;
        sdOut <= 1'b0;
        sdOe <= 1'b0;
    end else if (csRise) begin
        // Abandon frame; partial command dropped
        phase_reg <= PHASE_RESP;
        bitCnt_reg <= 5'h00;
        firstPending_reg <= 1'b0;
        sdOe <= 1'b0;
    end else if (csFall) begin
        // Pointer-selected word, first bit at once
        phase_reg <= PHASE_RESP;
        bitCnt_reg <= 5'h00;
        firstPending_reg <= 1'b0;
        sdOut <= curWord[15];
        sdOe <= ~curMask[15];
        txShift_reg <= {curWord[14:0], 1'b0};
        zShift_reg <= {curMask[14:0], 1'b0};
    end else if (sckRise) begin
        // Sample on rising edges
        rxShift_reg <= cmdWord;
        firstPending_reg <= 1'b0;
        if (lastBit) begin
            bitCnt_reg <= 5'h00;
            if (phase_reg == PHASE_RESP) begin
                phase_reg <= PHASE_CMD;
            end else begin
                phase_reg <= PHASE_RESP;
                firstPending_reg <= 1'b1;
                // Read selects, write keeps temperature
                txShift_reg <= nextWord;
                zShift_reg <= nextMask;
            end
        end else begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
        end
    end else if (sckFall) begin
        // Drive after falling edges, MSB first
        if (phase_reg == PHASE_RESP
            && (bitCnt_reg != 5'h00 || firstPending_reg)) begin
            sdOut <= txShift_reg[15];
            sdOe <= ~zShift_reg[15];
            txShift_reg <= txShift_reg << 1;
            zShift_reg <= zShift_reg << 1;
        end else if (phase_reg == PHASE_CMD) begin
            sdOe <= 1'b0;
        end
        firstPending_reg <= 1'b0;
    end
end

// ----------------------------------------
// Register file and read pointer
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        readPointer_reg <= `TSSCP_PTR_RESET;
        config_reg <= `TSSCP_CONFIG_RESET;
        lowLimit_reg <= `TSSCP_LOW_RESET;
        highLimit_reg <= `TSSCP_HIGH_RESET;
        shutdownReq_reg <= 1'b0;
    end else if (respDone) begin
        // Full read done
        readPointer_reg <= `TSSCP_PTR_TEMP;
    end else if (cmdDone) begin
        // Only complete commands get here
        if (isRead) begin
            readPointer_reg <= nextPtr;
        end else if (isShutdown) begin
            shutdownReq_reg <= 1'b1;
        end else begin
            shutdownReq_reg <= 1'b0;
            // Pointer untouched on writes
            if (isCfgWrite) begin
                config_reg <= cmdWord;
            end else if (isLowWrite) begin
                lowLimit_reg <= cmdWord;
            end else if (isHighWrite) begin
                highLimit_reg <= cmdWord;
            end
        end
    end
end

// ----------------------------------------
// Configuration field outputs
// ----------------------------------------
localparam [15:0] CFG_RESET = `TSSCP_CONFIG_RESET;

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        conversionDelayField <=
            CFG_RESET[`TSSCP_CFG_DELAY_HI:`TSSCP_CFG_DELAY_LO];
        resolutionField <=
            CFG_RESET[`TSSCP_CFG_RES_HI:`TSSCP_CFG_RES_LO];
        faultCountField <=
            CFG_RESET[`TSSCP_CFG_FAULT_HI:`TSSCP_CFG_FAULT_LO];
        alertPolarity <= CFG_RESET[`TSSCP_CFG_POL];
        thermostatModeField <=
            CFG_RESET[`TSSCP_CFG_TM_HI:`TSSCP_CFG_TM_LO];
    end else begin
        conversionDelayField <=
            config_reg[`TSSCP_CFG_DELAY_HI:`TSSCP_CFG_DELAY_LO];
        resolutionField <= config_reg[`TSSCP_CFG_RES_HI:`TSSCP_CFG_RES_LO];
        faultCountField <=
            config_reg[`TSSCP_CFG_FAULT_HI:`TSSCP_CFG_FAULT_LO];
        alertPolarity <= config_reg[`TSSCP_CFG_POL];
        thermostatModeField <= config_reg[`TSSCP_CFG_TM_HI:`TSSCP_CFG_TM_LO];
    end
end

endmodule

/* File: hdl/tsscp_defs.vh */
// Constants for the temperature sensor serial command port
`ifndef TSSCP_DEFS_VH
`define TSSCP_DEFS_VH

// ----------------------------------------
// Read pointer codes
// ----------------------------------------
`define TSSCP_PTR_TEMP 2'h0
`define TSSCP_PTR_CONFIG 2'h1
`define TSSCP_PTR_LOW 2'h2
`define TSSCP_PTR_HIGH 2'h3
`define TSSCP_PTR_RESET 2'h0

// ----------------------------------------
// Word framing
// ----------------------------------------
`define TSSCP_WORD_BITS 5'h10
`define TSSCP_READ_FLAG 15
`define TSSCP_SEL_HI 4
`define TSSCP_SEL_LO 3
`define TSSCP_READ_BASE 16'h8000
`define TSSCP_READ_MASK 16'hFFE7
`define TSSCP_SHUTDOWN_BYTE 8'hFF

// ----------------------------------------
// Write command tails and fixed bits
// ----------------------------------------
`define TSSCP_TAIL_CONFIG 3'h2
`define TSSCP_TAIL_LOW 3'h4
`define TSSCP_TAIL_HIGH 3'h6
`define TSSCP_TEMP_TAIL 3'h7
`define TSSCP_CFG_TOP 4'h0
`define TSSCP_TEMP_ZMASK 16'h0003
`define TSSCP_NO_ZMASK 16'h0000

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define TSSCP_CFG_DELAY_HI 11
`define TSSCP_CFG_DELAY_LO 10
`define TSSCP_CFG_RES_HI 9
`define TSSCP_CFG_RES_LO 8
`define TSSCP_CFG_FAULT_HI 7
`define TSSCP_CFG_FAULT_LO 6
`define TSSCP_CFG_POL 5
`define TSSCP_CFG_TM_HI 4
`define TSSCP_CFG_TM_LO 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSSCP_CONFIG_RESET 16'h0302
`define TSSCP_LOW_RESET 16'h2584
`define TSSCP_HIGH_RESET 16'h2806
`define TSSCP_TEMP_RESET 13'h0000

`endif

/* File: hdl/tsscp_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module tsscp_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] pinOut
);

reg [WIDTH-1:0] stage1_reg;
reg [WIDTH-1:0] stage2_reg;
reg [WIDTH-1:0] stage3_reg;

// ----------------------------------------
// Per-bit chain
// ----------------------------------------
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
        always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                stage1_reg[i] <= INIT[i];
                stage2_reg[i] <= INIT[i];
                stage3_reg[i] <= INIT[i];
                pinOut[i] <= INIT[i];
            end else begin
                stage1_reg[i] <= pinIn[i];
                stage2_reg[i] <= stage1_reg[i];
                stage3_reg[i] <= stage2_reg[i];
                // Accept once stages two and three agree
                if (stage2_reg[i] == stage3_reg[i]) begin
                    pinOut[i] <= stage3_reg[i];
                end
            end
        end
    end
endgenerate

endmodule

/* File: hdl/tsscp_conv.v */
// Conversion result holder and shutdown sequencing
`timescale 1ns/100ps
`include "tsscp_defs.vh"

module tsscp_conv (
    input wire clock,
    input wire rst_n,
    input wire adcDone,
    input wire adcBusy,
    input wire [12:0] adcResult,
    input wire shutdownReq,
    output reg [12:0] tempResult,
    output reg shutdownActive
);

// ----------------------------------------
// Latest completed result
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        tempResult <= `TSSCP_TEMP_RESET;
    end else if (adcDone && !shutdownActive) begin
        tempResult <= adcResult;
    end
end

// ----------------------------------------
// Shutdown once conversion ends
// ----------------------------------------
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        shutdownActive <= 1'b0;
    end else if (!shutdownReq) begin
        shutdownActive <= 1'b0;
    end else if (adcDone || !adcBusy) begin
        shutdownActive <= 1'b1;
    end
end

endmodule

/* File: test/tsscp_checker.sv */
// Concurrent checks on the serial command port pins
`timescale 1ns/100ps

module tsscp_checker (
    input wire clock,
    input wire rst_n,
    input wire csN,
    input wire sck,
    input wire sdOut,
    input wire sdOe,
    input wire adcDone,
    input wire adcBusy,
    input wire shutdownActive,
    input wire [1:0] conversionDelayField,
    input wire [1:0] resolutionField,
    input wire [1:0] faultCountField,
    input wire alertPolarity,
    input wire [1:0] thermostatModeField
);
    // ------
    // Clocking
    // ------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [8:0] fields = {conversionDelayField, resolutionField,
        faultCountField, alertPolarity, thermostatModeField};

    // ------
    // Properties
    // ------
    a_oe_idle: assert property (csN [*8] |-> !sdOe)
        else $error("data line driven while deselected");
    a_oe_start: assert property ($fell(csN) |->
        ##[1:8] (sdOe || csN))
        else $error("no response after select");
    a_oe_cause: assert property ($rose(sdOe) |-> !$past(csN, 3))
        else $error("drive began without select");
    a_out_edge: assert property (sdOe && $changed(sdOut) |-> !sck)
        else $error("output changed with serial clock high");
    a_cfg_quiet: assert property (csN [*8] |-> $stable(fields))
        else $error("config changed outside a frame");
    a_cfg_reset: assert property ($rose(rst_n) |-> fields == 9'h060)
        else $error("config fields wrong after reset");
    a_shut_cause: assert property ($rose(shutdownActive) |->
        $past(adcDone) || !$past(adcBusy))
        else $error("shutdown entered mid conversion");
    a_shut_keep: assert property (csN [*8] |->
        !$fell(shutdownActive))
        else $error("shutdown left without command");
endmodule

bind tsscp_top tsscp_checker u_chk (.clock(clock), .rst_n(rst_n),
    .csN(csN), .sck(sck), .sdOut(sdOut), .sdOe(sdOe), .adcDone(adcDone),
    .adcBusy(adcBusy), .shutdownActive(shutdownActive),
    .conversionDelayField(conversionDelayField),
    .resolutionField(resolutionField), .faultCountField(faultCountField),
    .alertPolarity(alertPolarity), .thermostatModeField(thermostatModeField));

/* File: test/tsscp_host.sv */
// Serial master model for the command port
`timescale 1ns/100ps

module tsscp_host (
    input wire clock,
    input wire line,
    input wire devOe,
    output logic csN,
    output logic sck,
    output logic hostBit,
    output logic hostOe
);
    initial begin
        csN = 1'b1;
        sck = 1'b0;
        hostBit = 1'b0;
        hostOe = 1'b0;
    end

    // ------
    // Frame control
    // ------
    task automatic select(input logic level);
        repeat (6) @(negedge clock);
        csN = level;
        repeat (6) @(negedge clock);
    endtask

    // Partial counts end a word early
    task automatic shift(input logic [15:0] tx, input logic drive,
        input int nBits, output logic [15:0] rx, output logic [15:0] oe);
        rx = 16'h0000;
        oe = 16'h0000;
        hostOe = drive;
        for (int i = 15; i > 15 - nBits; i--) begin
            hostBit = tx[i];
            repeat (6) @(negedge clock);
            rx[i] = line;
            oe[i] = devOe;
            sck = 1'b1;
            repeat (2) @(negedge clock);
            sck = 1'b0;
        end
        @(negedge clock);
        hostOe = 1'b0;
    endtask
endmodule

/* File: test/test_temp_sensor_serial_command_port.sv */
// Testbench for the temperature sensor serial command port
`timescale 1ns/100ps

module test_temp_sensor_serial_command_port;
    logic clock, rst_n, adcDone, adcBusy, floatBit, line;
    logic [12:0] adcResult;
    logic csN, sck, hostBit, hostOe, sdOut, sdOe, shutdownActive, alert_polarity;
    logic [1:0] delayF, resF, faultF, tmF;
    logic [15:0] rx, oe, temp;
    int errors, comparisons;
    wire [8:0] fields = {delayF, resF, faultF, alert_polarity, tmF};

    // Floating line shows a changing pattern
    assign line = sdOe ? sdOut : (hostOe ? hostBit : floatBit);

    tsscp_top u_dut (.clock(clock), .rst_n(rst_n), .csN(csN), .sck(sck),
        .sdIn(line), .sdOut(sdOut), .sdOe(sdOe), .adcDone(adcDone),
        .adcBusy(adcBusy), .adcResult(adcResult),
        .shutdownActive(shutdownActive), .conversionDelayField(delayF),
        .resolutionField(resF), .faultCountField(faultF),
        .alertPolarity(alert_polarity), .thermostatModeField(tmF));
    tsscp_host u_host (.clock(clock), .line(line), .devOe(sdOe), .csN(csN),
        .sck(sck), .hostBit(hostBit), .hostOe(hostOe));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(negedge clock) floatBit <= ~floatBit;

    // ------
    // Tasks
    // ------
    task automatic chkWord(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chkFlag(input string name, input logic exp, input logic got);
        chkWord(name, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic rd(input logic [15:0] exp, input logic [15:0] mask);
        u_host.shift(16'h0000, 1'b0, 16, rx, oe);
        chkWord("word", exp & mask, rx & mask);
        chkWord("enable", mask, oe);
    endtask
    task automatic cmd(input logic [15:0] c);
        u_host.shift(c, 1'b1, 16, rx, oe);
    endtask
    task automatic conv(input logic [12:0] v);
        adcResult = v;
        adcDone = 1'b1;
        temp = {v, 3'h4};
        @(negedge clock);
        adcDone = 1'b0;
    endtask
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (60000) @(negedge clock);
        errors++;
        finish_test();
    end

    // ------
    // Sequence
    // ------
    initial begin
        rst_n = 1'b0;
        adcDone = 1'b0;
        adcBusy = 1'b1;
        adcResult = 13'h0000;
        floatBit = 1'b0;
        errors = 0;
        comparisons = 0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chkWord("fields", 16'h0060, {7'h00, fields});
        chkFlag("shutdown", 1'b0, shutdownActive);
        conv(13'h0190);
        u_host.select(1'b0);
        rd(16'h0C84, 16'hFFFC);
        cmd(16'h8008);
        rd(16'h0302, 16'hFFFF);
        cmd(16'h1234);
        rd(temp, 16'hFFFC);
        cmd(16'h8010);
        rd(16'h1234, 16'hFFFF);
        conv(13'h1F38);
        cmd(16'h2346);
        rd(temp, 16'hFFFC);
        cmd(16'h8018);
        rd(16'h2346, 16'hFFFF);
        cmd(16'h0CAA);
        rd(temp, 16'hFFFC);
        u_host.select(1'b1);
        chkWord("fields", 16'h0195, {7'h00, fields});
        $display("test registers done");
        u_host.select(1'b0);
        rd(temp, 16'hFFFC);
        cmd(16'h8008);
        u_host.shift(16'h0000, 1'b0, 4, rx, oe);
        u_host.select(1'b1);
        u_host.select(1'b0);
        rd(16'h0CAA, 16'hFFFF);
        u_host.select(1'b1);
        u_host.select(1'b0);
        rd(temp, 16'hFFFC);
        u_host.shift(16'h5554, 1'b1, 8, rx, oe);
        u_host.select(1'b1);
        u_host.select(1'b0);
        rd(temp, 16'hFFFC);
        cmd(16'h8010);
        rd(16'h1234, 16'hFFFF);
        $display("test early end done");
        cmd(16'h00FF);
        rd(temp, 16'hFFFC);
        chkFlag("shutdown", 1'b0, shutdownActive);
        conv(13'h0010);
        chkFlag("shutdown", 1'b1, shutdownActive);
        conv(13'h0777);
        cmd(16'h8000);
        rd(16'h0084, 16'hFFFC);
        chkFlag("shutdown", 1'b1, shutdownActive);
        cmd(16'h0001);
        rd(16'h0084, 16'hFFFC);
        chkFlag("shutdown", 1'b0, shutdownActive);
        adcBusy = 1'b0;
        cmd(16'h00FF);
        rd(16'h0084, 16'hFFFC);
        chkFlag("shutdown", 1'b1, shutdownActive);
        adcBusy = 1'b1;
        cmd(16'h0001);
        rd(16'h0084, 16'hFFFC);
        chkFlag("shutdown", 1'b0, shutdownActive);
        u_host.select(1'b1);
        $display("test shutdown done");
        finish_test();
    end
endmodule
